/* File: design/eis_irq_status.sv */
// Interrupt and status logic of the Ethernet controller
//
// Functional notes
// - Status bit 7 shows any enabled flag set.
// - Buffer overrun or underrun sets status bit 6, host clearable.
// - Collision after 64 transmitted bytes sets status bit 4, host clearable.
// - Status bit 2 follows receive busy.
// - Aborted transmit sets status bit 1, host clearable.
// - Clock ready bit 0 sets when start-up timer done and PHY ready.
// - Clock ready cleared only by power-on reset.
// - Global enable zero keeps interrupt pin high.
// - Per-source enables at bits 6,5,4,3,1,0; bit 2 stays zero.
// - Packet pending flag high while count nonzero; cleared by decrement.
// - DMA completion sets DMA flag, host clearable.
// - Link flag read-only, cleared by reading PHY request register.
// - Transmit end sets transmit flag, host clearable.
// - Transmit error sets transmit error flag, host clearable.
// - No space or count 255 discards packet, sets receive error flag.
// - Receive error flag holds until host clear or reset.
// - Receive error drives pin when its enable and global enable set.
// - PHY enable register: link enable bit 4, global bit 1.
// - PHY link flag bit 4 set on change, cleared on read.
// - PHY global flag bit 2 for enabled events, cleared on read.
// - Pin stays low until causing flags cleared or masked.
// - Link flag mirrors PHY global flag only with both PHY enables.
`timescale 1ns/1ps
`include "eis_defines.svh"
module eis_irq_status
  import eis_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        sys_rst_in,
  input  eis_cmd_s         cmd_in,
  output logic      [7:0]  rd_data_out,
  output logic             rd_valid_out,
  input  eis_phy_cmd_s     phy_cmd_in,
  output logic      [15:0] phy_rdata_out,
  output logic             phy_rvalid_out,
  input  eis_events_s      events_in,
  input  wire logic        rx_busy_in,
  input  wire logic        ost_done_in,
  input  wire logic        phy_ready_in,
  input  wire logic        pkt_dec_in,
  output logic      [7:0]  pkt_count_out,
  output logic             rx_discard_out,
  output logic             int_n_out
);

  // Clear mask from a host access, for clearable bits only
  function automatic logic [7:0] clr_mask(input eis_op_e op,
                                          input logic [7:0] wdata,
                                          input logic [7:0] cmask);
    logic [7:0] m;
    m = 8'h00;
    unique case (op)
      EIS_OP_WRITE: m = ~wdata;
      EIS_OP_BFC:   m = wdata;
      EIS_OP_READ:  m = 8'h00;
      EIS_OP_BFS:   m = 8'h00;
    endcase
    return m & cmask;
  endfunction

  // Address hit for a given register
  function automatic logic hit(input eis_cmd_s c, input logic [4:0] a);
    return c.valid && (c.addr == a);
  endfunction

  logic        st_sel;
  logic        ie_sel;
  logic        if_sel;
  logic        phy_irq_enable_wr;
  logic        phy_irq_flags_rd;
  logic [7:0]  st_set;
  logic [7:0]  st_clr;
  logic [7:0]  st_flags;
  logic [7:0]  if_set;
  logic [7:0]  if_clr;
  logic [7:0]  if_flags;
  logic [7:0]  eie_r;
  logic [7:0]  eie_nxt;
  logic [7:0]  pkt_cnt_r;
  logic [7:0]  pkt_cnt_nxt;
  logic        pkt_flag_r;
  logic        rx_busy_r;
  logic        clk_rdy_r;
  logic        rx_overflow;
  logic        pkt_full;
  logic [15:0] phy_irq_enable;
  logic        phy_link_change_flag;
  logic        phy_global_irq_flag;
  logic        link_flag;
  logic [7:0]  eir_view;
  logic [7:0]  ethernet_status_view;
  logic        pending;
  logic        pend_r;

  assign st_sel  = hit(cmd_in, `EIS_ADDR_ETHERNET_STATUS);
  assign ie_sel  = hit(cmd_in, `EIS_ADDR_EIE);
  assign if_sel  = hit(cmd_in, `EIS_ADDR_EIR);
  assign phy_irq_enable_wr = phy_cmd_in.valid && phy_cmd_in.write
                   && (phy_cmd_in.addr == `EIS_ADDR_PHY_IRQ_ENABLE);
  assign phy_irq_flags_rd = phy_cmd_in.valid && !phy_cmd_in.write
                   && (phy_cmd_in.addr == `EIS_ADDR_PHY_IRQ_FLAGS);

  // Status sticky sources
  always_comb begin
    st_set = 8'h00;
    st_set[`EIS_ST_BUFERR]  = events_in.buf_err;
    st_set[`EIS_ST_LATE_COLLISION_ERROR] = events_in.late_col;
    st_set[`EIS_ST_TXABORT] = events_in.tx_abort;
  end

  assign st_clr = st_sel ? clr_mask(cmd_in.op, cmd_in.wdata, `EIS_ST_CLR_MASK) : 8'h00;

  eis_sticky_bank u_status_flags (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .sys_clr_in (sys_rst_in),
    .set_in     (st_set),
    .clr_in     (st_clr),
    .flags_out  (st_flags)
  );

  // Packet counter and receive overflow
  assign pkt_full = (pkt_cnt_r == `EIS_PKT_MAX);
  assign rx_overflow = events_in.rx_no_space || (events_in.rx_pkt_done && pkt_full);

  always_comb begin
    pkt_cnt_nxt = pkt_cnt_r;
    if (events_in.rx_pkt_done && !pkt_full && !(pkt_dec_in && pkt_cnt_r != `EIS_PKT_ZERO)) begin
      pkt_cnt_nxt = pkt_cnt_r + 8'h01;
    end else if (pkt_dec_in && pkt_cnt_r != `EIS_PKT_ZERO
                 && !(events_in.rx_pkt_done && !pkt_full)) begin
      pkt_cnt_nxt = pkt_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pkt_cnt_r <= `EIS_PKT_ZERO;
    end else if (sys_rst_in) begin
      pkt_cnt_r <= `EIS_PKT_ZERO;
    end else begin
      pkt_cnt_r <= pkt_cnt_nxt;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pkt_count_out <= `EIS_PKT_ZERO;
    end else if (sys_rst_in) begin
      pkt_count_out <= `EIS_PKT_ZERO;
    end else begin
      pkt_count_out <= pkt_cnt_nxt;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pkt_flag_r <= 1'b0;
    end else if (sys_rst_in) begin
      pkt_flag_r <= 1'b0;
    end else begin
      pkt_flag_r <= (pkt_cnt_nxt != `EIS_PKT_ZERO);
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_discard_out <= 1'b0;
    end else if (sys_rst_in) begin
      rx_discard_out <= 1'b0;
    end else begin
      rx_discard_out <= rx_overflow;
    end
  end

  // Flag sticky sources
  always_comb begin
    if_set = 8'h00;
    if_set[`EIS_IF_DMA]   = events_in.dma_done;
    if_set[`EIS_IF_TX]    = events_in.tx_end || events_in.tx_err;
    if_set[`EIS_IF_TXERR] = events_in.tx_err;
    if_set[`EIS_IF_RXERR] = rx_overflow;
  end

  assign if_clr = if_sel ? clr_mask(cmd_in.op, cmd_in.wdata, `EIS_EIR_CLR_MASK) : 8'h00;

  eis_sticky_bank u_irq_flags (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .sys_clr_in (sys_rst_in),
    .set_in     (if_set),
    .clr_in     (if_clr),
    .flags_out  (if_flags)
  );

  // Enable register
  always_comb begin
    eie_nxt = eie_r;
    if (ie_sel) begin
      unique case (cmd_in.op)
        EIS_OP_WRITE: eie_nxt = cmd_in.wdata;
        EIS_OP_BFS:   eie_nxt = eie_r | cmd_in.wdata;
        EIS_OP_BFC:   eie_nxt = eie_r & ~cmd_in.wdata;
        EIS_OP_READ:  eie_nxt = eie_r;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      eie_r <= `EIS_REG8_RST;
    end else if (sys_rst_in) begin
      eie_r <= `EIS_REG8_RST;
    end else begin
      eie_r <= eie_nxt & `EIS_EIE_WR_MASK;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_busy_r <= 1'b0;
    end else if (sys_rst_in) begin
      rx_busy_r <= 1'b0;
    end else begin
      rx_busy_r <= rx_busy_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_rdy_r <= 1'b0;
    end else if (ost_done_in && phy_ready_in) begin
      clk_rdy_r <= 1'b1;
    end
  end

  // PHY interrupt registers
  eis_phy_irq u_phy_irq (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .sys_clr_in    (sys_rst_in),
    .wr_en_in      (phy_irq_enable_wr),
    .wdata_in      (phy_cmd_in.wdata),
    .rd_clr_in     (phy_irq_flags_rd),
    .link_event_in (events_in.link_change),
    .phy_irq_enable_out      (phy_irq_enable),
    .phy_link_change_flag_out    (phy_link_change_flag),
    .phy_global_irq_flag_out      (phy_global_irq_flag)
  );

  // link flag shadows PHY global flag
  assign link_flag = phy_global_irq_flag && phy_irq_enable[`EIS_PH_LINK] && phy_irq_enable[`EIS_PH_GLOBAL];

  always_comb begin
    eir_view = if_flags;
    eir_view[`EIS_IF_PKT]  = pkt_flag_r;
    eir_view[`EIS_IF_LINK] = link_flag;
    eir_view[7]            = 1'b0;
    eir_view[2]            = 1'b0;
  end

  assign pending = |(eir_view[6:0] & eie_r[6:0] & `EIS_EIR_SRC_MASK);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_r <= 1'b0;
    end else if (sys_rst_in) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= pending;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      int_n_out <= 1'b1;
    end else if (sys_rst_in) begin
      int_n_out <= 1'b1;
    end else begin
      int_n_out <= !(pending && eie_r[`EIS_IE_GLOBAL]);
    end
  end

  always_comb begin
    ethernet_status_view = 8'h00;
    ethernet_status_view[`EIS_ST_PEND]    = pend_r;
    ethernet_status_view[`EIS_ST_BUFERR]  = st_flags[`EIS_ST_BUFERR];
    ethernet_status_view[`EIS_ST_LATE_COLLISION_ERROR] = st_flags[`EIS_ST_LATE_COLLISION_ERROR];
    ethernet_status_view[`EIS_ST_RECEIVE_BUSY]  = rx_busy_r;
    ethernet_status_view[`EIS_ST_TXABORT] = st_flags[`EIS_ST_TXABORT];
    ethernet_status_view[`EIS_ST_CLOCK_READY]  = clk_rdy_r;
  end

  // Control register readback
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= `EIS_REG8_RST;
    end else if (cmd_in.valid && cmd_in.op == EIS_OP_READ) begin
      if (st_sel) begin
        rd_data_out <= ethernet_status_view;
      end else if (ie_sel) begin
        rd_data_out <= eie_r;
      end else if (if_sel) begin
        rd_data_out <= eir_view;
      end else begin
        rd_data_out <= `EIS_REG8_RST;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= cmd_in.valid && cmd_in.op == EIS_OP_READ;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phy_rdata_out <= `EIS_REG16_RST;
    end else if (phy_cmd_in.valid && !phy_cmd_in.write) begin
      if (phy_cmd_in.addr == `EIS_ADDR_PHY_IRQ_ENABLE) begin
        phy_rdata_out <= phy_irq_enable;
      end else if (phy_irq_flags_rd) begin
        phy_rdata_out <= {11'h000, phy_link_change_flag, 1'b0, phy_global_irq_flag, 2'h0};
      end else begin
        phy_rdata_out <= `EIS_REG16_RST;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phy_rvalid_out <= 1'b0;
    end else begin
      phy_rvalid_out <= phy_cmd_in.valid && !phy_cmd_in.write;
    end
  end

endmodule

/* File: inc/eis_defines.svh */
// Offsets, field positions, masks and reset values of the interrupt/status block
`ifndef EIS_DEFINES_SVH
`define EIS_DEFINES_SVH

// Control register offsets on the command port
`define EIS_ADDR_ETHERNET_STATUS      5'h10
`define EIS_ADDR_EIE        5'h11
`define EIS_ADDR_EIR        5'h12
// PHY register offsets on the PHY access port
`define EIS_ADDR_PHY_IRQ_ENABLE       5'h02
`define EIS_ADDR_PHY_IRQ_FLAGS       5'h03

// Status register fields
`define EIS_ST_PEND         7
`define EIS_ST_BUFERR       6
`define EIS_ST_LATE_COLLISION_ERROR      4
`define EIS_ST_RECEIVE_BUSY       2
`define EIS_ST_TXABORT      1
`define EIS_ST_CLOCK_READY       0
`define EIS_ST_CLR_MASK     8'h52

// Enable and flag fields (same positions in both registers)
`define EIS_IE_GLOBAL       7
`define EIS_IF_PKT          6
`define EIS_IF_DMA          5
`define EIS_IF_LINK         4
`define EIS_IF_TX           3
`define EIS_IF_TXERR        1
`define EIS_IF_RXERR        0
`define EIS_EIE_WR_MASK     8'hfb
`define EIS_EIR_CLR_MASK    8'h2b
`define EIS_EIR_SRC_MASK    7'h7b

// PHY interrupt fields
`define EIS_PH_LINK         4
`define EIS_PH_GLOBAL       1
`define EIS_PH_GFLAG        2
`define EIS_PHY_IRQ_ENABLE_WR_MASK    16'h0012

// Reset values and limits
`define EIS_REG8_RST        8'h00
`define EIS_REG16_RST       16'h0000
`define EIS_PKT_MAX         8'hff
`define EIS_PKT_ZERO        8'h00

`endif

/* File: inc/eis_pkg.sv */
// Types shared by the interrupt/status block
package eis_pkg;

  typedef enum logic [1:0] {
    EIS_OP_READ  = 2'b00,
    EIS_OP_WRITE = 2'b01,
    EIS_OP_BFS   = 2'b10,
    EIS_OP_BFC   = 2'b11
  } eis_op_e;

  typedef struct packed {
    logic buf_err;
    logic late_col;
    logic tx_abort;
    logic dma_done;
    logic tx_end;
    logic tx_err;
    logic rx_no_space;
    logic rx_pkt_done;
    logic link_change;
  } eis_events_s;

  typedef struct packed {
    logic       valid;
    eis_op_e    op;
    logic [4:0] addr;
    logic [7:0] wdata;
  } eis_cmd_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } eis_phy_cmd_s;

endpackage

/* File: design/eis_sticky_bank.sv */
// Eight sticky flags, set wins over clear
`timescale 1ns/1ps
`include "eis_defines.svh"
module eis_sticky_bank
  import eis_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       sys_clr_in,
  input  wire logic [7:0] set_in,
  input  wire logic [7:0] clr_in,
  output logic      [7:0] flags_out
);

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          flags_out[i] <= 1'b0;
        end else if (sys_clr_in) begin
          flags_out[i] <= 1'b0;
        end else if (set_in[i]) begin
          flags_out[i] <= 1'b1;
        end else if (clr_in[i]) begin
          flags_out[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

/* File: design/eis_phy_irq.sv */
// PHY interrupt enable and self-clearing request flags
`timescale 1ns/1ps
`include "eis_defines.svh"
module eis_phy_irq
  import eis_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        sys_clr_in,
  input  wire logic        wr_en_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        rd_clr_in,
  input  wire logic        link_event_in,
  output logic      [15:0] phy_irq_enable_out,
  output logic             phy_link_change_flag_out,
  output logic             phy_global_irq_flag_out
);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phy_irq_enable_out <= `EIS_REG16_RST;
    end else if (sys_clr_in) begin
      phy_irq_enable_out <= `EIS_REG16_RST;
    end else if (wr_en_in) begin
      phy_irq_enable_out <= wdata_in & `EIS_PHY_IRQ_ENABLE_WR_MASK;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phy_link_change_flag_out <= 1'b0;
    end else if (sys_clr_in) begin
      phy_link_change_flag_out <= 1'b0;
    end else if (link_event_in) begin
      phy_link_change_flag_out <= 1'b1;
    end else if (rd_clr_in) begin
      phy_link_change_flag_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phy_global_irq_flag_out <= 1'b0;
    end else if (sys_clr_in) begin
      phy_global_irq_flag_out <= 1'b0;
    end else if (link_event_in && phy_irq_enable_out[`EIS_PH_LINK]) begin
      phy_global_irq_flag_out <= 1'b1;
    end else if (rd_clr_in) begin
      phy_global_irq_flag_out <= 1'b0;
    end
  end

endmodule

/* File: verification/eis_irq_status_chk.sv */
// Assertion checker of the interrupt/status block
`timescale 1ns/1ps
`include "eis_defines.svh"
module eis_irq_status_chk
  import eis_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        sys_rst_in,
  input  eis_cmd_s         cmd_in,
  input  wire logic [7:0]  rd_data_out,
  input  eis_phy_cmd_s     phy_cmd_in,
  input  wire logic [15:0] phy_rdata_out,
  input  eis_events_s      events_in,
  input  wire logic        rx_busy_in,
  input  wire logic        ost_done_in,
  input  wire logic        phy_ready_in,
  input  wire logic        pkt_dec_in,
  input  wire logic [7:0]  pkt_count_out,
  input  wire logic        rx_discard_out,
  input  wire logic        int_n_out
);
  logic g_r, rdy_r, rdy2_r, pclr_r, q1_r, q2_r;
  logic q, rd_st, rd_p3, en_wr, full_in;
  assign q = !cmd_in.valid && !phy_cmd_in.valid && !pkt_dec_in && !sys_rst_in;
  assign rd_st = cmd_in.valid && cmd_in.op == EIS_OP_READ && cmd_in.addr == `EIS_ADDR_ETHERNET_STATUS;
  assign rd_p3 = phy_cmd_in.valid && !phy_cmd_in.write && phy_cmd_in.addr == `EIS_ADDR_PHY_IRQ_FLAGS;
  assign en_wr = cmd_in.valid && cmd_in.addr == `EIS_ADDR_EIE;
  assign full_in = events_in.rx_pkt_done && !pkt_dec_in && !sys_rst_in;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // Global enable shadow
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) g_r <= 1'b0;
    else if (sys_rst_in) g_r <= 1'b0;
    else if (en_wr && cmd_in.op == EIS_OP_WRITE) g_r <= cmd_in.wdata[7];
    else if (en_wr && cmd_in.op == EIS_OP_BFS) g_r <= g_r | cmd_in.wdata[7];
    else if (en_wr && cmd_in.op == EIS_OP_BFC) g_r <= g_r & ~cmd_in.wdata[7];
  end
  // Clock ready history, power-on reset only
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) {rdy_r, rdy2_r} <= 2'b00;
    else {rdy_r, rdy2_r} <= {rdy_r | (ost_done_in & phy_ready_in), rdy_r};
  end
  // PHY flags known clear since last read
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) pclr_r <= 1'b0;
    else if (events_in.link_change) pclr_r <= 1'b0;
    else if (rd_p3) pclr_r <= 1'b1;
  end
  // Quiet host history
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) {q1_r, q2_r} <= 2'b00;
    else {q1_r, q2_r} <= {q, q1_r};
  end

  property p_pkt_inc;
    full_in && pkt_count_out != `EIS_PKT_MAX |=> pkt_count_out == $past(pkt_count_out) + 8'h01;
  endproperty
  a_pkt_inc: assert property (p_pkt_inc) else $error("packet count not incremented");
  property p_pkt_dec;
    pkt_dec_in && !events_in.rx_pkt_done && !sys_rst_in && pkt_count_out != `EIS_PKT_ZERO
      |=> pkt_count_out == $past(pkt_count_out) - 8'h01;
  endproperty
  a_pkt_dec: assert property (p_pkt_dec) else $error("packet count not decremented");
  property p_full_hold;
    full_in && pkt_count_out == `EIS_PKT_MAX |=> pkt_count_out == `EIS_PKT_MAX;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("full packet count changed");
  property p_discard;
    full_in && pkt_count_out == `EIS_PKT_MAX |-> ##[1:2] rx_discard_out;
  endproperty
  a_discard: assert property (p_discard) else $error("no discard at full count");
  property p_glb_off;
    !g_r [*3] |-> int_n_out;
  endproperty
  a_glb_off: assert property (p_glb_off) else $error("pin low with global enable off");
  property p_hold_low;
    !int_n_out && q && q1_r && q2_r |=> sys_rst_in || !int_n_out;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("pin released without host action");
  property p_phy_clr;
    rd_p3 && pclr_r && !events_in.link_change |=> phy_rdata_out[4] == 1'b0 && phy_rdata_out[2] == 1'b0;
  endproperty
  a_phy_clr: assert property (p_phy_clr) else $error("PHY flags not cleared by read");
  property p_resv;
    cmd_in.valid && cmd_in.op == EIS_OP_READ && cmd_in.addr inside {`EIS_ADDR_EIE, `EIS_ADDR_EIR}
      |=> rd_data_out[2] == 1'b0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit 2 read as one");
  property p_clk_rdy;
    rd_st && (rdy2_r || !(rdy_r || (ost_done_in && phy_ready_in))) |=> rd_data_out[0] == $past(rdy2_r);
  endproperty
  a_clk_rdy: assert property (p_clk_rdy) else $error("clock ready bit wrong");
  property p_rx_busy;
    rd_st && $stable(rx_busy_in) && !$past(sys_rst_in) |=> rd_data_out[2] == $past(rx_busy_in);
  endproperty
  a_rx_busy: assert property (p_rx_busy) else $error("receive busy bit wrong");

  c_full: cover property (full_in && pkt_count_out == `EIS_PKT_MAX);
  c_int: cover property ($fell(int_n_out));
  c_phy: cover property (rd_p3 && pclr_r);
endmodule

bind eis_irq_status eis_irq_status_chk i_eis_irq_status_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .sys_rst_in(sys_rst_in), .cmd_in(cmd_in),
  .rd_data_out(rd_data_out), .phy_cmd_in(phy_cmd_in), .phy_rdata_out(phy_rdata_out),
  .events_in(events_in), .rx_busy_in(rx_busy_in), .ost_done_in(ost_done_in),
  .phy_ready_in(phy_ready_in), .pkt_dec_in(pkt_dec_in), .pkt_count_out(pkt_count_out),
  .rx_discard_out(rx_discard_out), .int_n_out(int_n_out));

/* File: verification/eis_host_model.sv */
// Host model driving the command, PHY and decrement ports
`timescale 1ns/1ps
`include "eis_defines.svh"
module eis_host_model
  import eis_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic [7:0]  rd_data_in,
  input  wire logic        rd_valid_in,
  input  wire logic [15:0] phy_rdata_in,
  input  wire logic        phy_rvalid_in,
  output eis_cmd_s         cmd_out,
  output eis_phy_cmd_s     phy_cmd_out,
  output logic             pkt_dec_out
);
  initial begin
    cmd_out = '0;
    phy_cmd_out = '0;
    pkt_dec_out = 1'b0;
  end
  // Released commands show inverted address and data, with valid low and op or write kept
  task automatic wr(input eis_op_e op, input logic [4:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    cmd_out = '{1'b1, op, a, d};
    @(negedge mclk_in);
    cmd_out = '{1'b0, op, ~a, ~d};
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic v);
    wr(EIS_OP_READ, a, 8'h00);
    d = rd_data_in;
    v = rd_valid_in;
  endtask
  task automatic pacc(input logic w, input logic [4:0] a, input logic [15:0] wd,
                      output logic [15:0] d, output logic v);
    @(negedge mclk_in);
    phy_cmd_out = '{1'b1, w, a, wd};
    @(negedge mclk_in);
    phy_cmd_out = '{1'b0, w, ~a, ~wd};
    d = phy_rdata_in;
    v = phy_rvalid_in;
  endtask
  task automatic clr_rx_err();
    wr(EIS_OP_BFC, `EIS_ADDR_EIR, 8'h01);
  endtask
  task automatic recover(input int n);
    repeat (n) begin
      @(negedge mclk_in);
      pkt_dec_out = 1'b1;
      @(negedge mclk_in);
      pkt_dec_out = 1'b0;
    end
  endtask
endmodule

/* File: verification/eis_irq_status_tb.sv */
// Testbench of the interrupt/status block
`timescale 1ns/1ps
`include "eis_defines.svh"
module eis_irq_status_tb
  import eis_pkg::*;
;
  logic         mclk, rst, sys_rst, rx_busy, ost, phyrdy, pkt_dec, rd_valid, phy_rvalid;
  logic         discard, int_n, v;
  int           n_disc = 0;
  int           disc0;
  logic [7:0]   rd_data, pkt_count;
  logic [15:0]  phy_rdata, pd;
  eis_cmd_s     cmd;
  eis_phy_cmd_s phy_cmd;
  eis_events_s  ev;
  int           n_fail, check_count;

  eis_irq_status i_eis_irq_status (
    .mclk_in(mclk), .rst_in(rst), .sys_rst_in(sys_rst), .cmd_in(cmd), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .phy_cmd_in(phy_cmd), .phy_rdata_out(phy_rdata),
    .phy_rvalid_out(phy_rvalid), .events_in(ev), .rx_busy_in(rx_busy), .ost_done_in(ost),
    .phy_ready_in(phyrdy), .pkt_dec_in(pkt_dec), .pkt_count_out(pkt_count),
    .rx_discard_out(discard), .int_n_out(int_n));
  eis_host_model host (
    .mclk_in(mclk), .rd_data_in(rd_data), .rd_valid_in(rd_valid), .phy_rdata_in(phy_rdata),
    .phy_rvalid_in(phy_rvalid), .cmd_out(cmd), .phy_cmd_out(phy_cmd), .pkt_dec_out(pkt_dec));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) if (discard === 1'b1) n_disc <= n_disc + 1;

  task automatic chk(input logic [16:0] act, input logic [16:0] exp);
    check_count++;
    if (act !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d, v);
    chk({8'h00, v, d}, {8'h00, 1'b1, e});
  endtask
  task automatic pchk(input logic [4:0] a, input logic [15:0] e);
    host.pacc(1'b0, a, 16'h0000, pd, v);
    chk({v, pd}, {1'b1, e});
  endtask
  task automatic pulse(input logic [8:0] p);
    @(negedge mclk);
    ev = p;
    @(negedge mclk);
    ev = '0;
  endtask
  task automatic ichk(input logic e);
    repeat (4) @(negedge mclk);
    chk({16'h0000, int_n}, {16'h0000, e});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {rst, sys_rst, rx_busy, ost, phyrdy} = 5'b10000;
    ev = '0;
    n_fail = 0;
    check_count = 0;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    rchk(`EIS_ADDR_ETHERNET_STATUS, 8'h00);
    rchk(`EIS_ADDR_EIE, 8'h00);
    rchk(`EIS_ADDR_EIR, 8'h00);
    rchk(5'h05, 8'h00);
    pchk(`EIS_ADDR_PHY_IRQ_ENABLE, 16'h0000);
    pchk(`EIS_ADDR_PHY_IRQ_FLAGS, 16'h0000);
    ichk(1'b1);
    ost = 1'b1;
    phyrdy = 1'b1;
    repeat (3) @(negedge mclk);
    rchk(`EIS_ADDR_ETHERNET_STATUS, 8'h01);
    @(negedge mclk);
    sys_rst = 1'b1;
    @(negedge mclk);
    sys_rst = 1'b0;
    rchk(`EIS_ADDR_ETHERNET_STATUS, 8'h01);
    $display("test reset done");
    rx_busy = 1'b1;
    pulse(9'h100);
    pulse(9'h080);
    pulse(9'h040);
    rchk(`EIS_ADDR_ETHERNET_STATUS, 8'h57);
    host.wr(EIS_OP_WRITE, `EIS_ADDR_ETHERNET_STATUS, 8'h00);
    rx_busy = 1'b0;
    repeat (2) @(negedge mclk);
    rchk(`EIS_ADDR_ETHERNET_STATUS, 8'h01);
    $display("test status done");
    pulse(9'h020);
    pulse(9'h010);
    pulse(9'h008);
    pulse(9'h004);
    rchk(`EIS_ADDR_EIR, 8'h2b);
    host.wr(EIS_OP_WRITE, `EIS_ADDR_EIR, 8'h01);
    rchk(`EIS_ADDR_EIR, 8'h01);
    ichk(1'b1);
    host.wr(EIS_OP_WRITE, `EIS_ADDR_EIE, 8'hff);
    rchk(`EIS_ADDR_EIE, 8'hfb);
    ichk(1'b0);
    rchk(`EIS_ADDR_ETHERNET_STATUS, 8'h81);
    host.wr(EIS_OP_BFC, `EIS_ADDR_EIE, 8'h80);
    ichk(1'b1);
    host.wr(EIS_OP_BFS, `EIS_ADDR_EIE, 8'h80);
    ichk(1'b0);
    host.clr_rx_err();
    ichk(1'b1);
    rchk(`EIS_ADDR_EIR, 8'h00);
    pulse(9'h020);
    fork
      host.wr(EIS_OP_BFC, `EIS_ADDR_EIR, 8'h20);
      pulse(9'h020);
    join
    rchk(`EIS_ADDR_EIR, 8'h20);
    host.wr(EIS_OP_BFC, `EIS_ADDR_EIR, 8'h20);
    rchk(`EIS_ADDR_EIR, 8'h00);
    $display("test flags done");
    host.wr(EIS_OP_WRITE, `EIS_ADDR_EIE, 8'hc0);
    pulse(9'h002);
    pulse(9'h002);
    chk({9'h000, pkt_count}, 17'h00002);
    rchk(`EIS_ADDR_EIR, 8'h40);
    host.recover(1);
    ichk(1'b0);
    host.recover(1);
    ichk(1'b1);
    host.wr(EIS_OP_WRITE, `EIS_ADDR_EIE, 8'h00);
    repeat (255) pulse(9'h002);
    chk({9'h000, pkt_count}, 17'h000ff);
    disc0 = n_disc;
    pulse(9'h002);
    repeat (2) @(negedge mclk);
    chk({8'h00, (n_disc == disc0 + 1), pkt_count}, 17'h001ff);
    rchk(`EIS_ADDR_EIR, 8'h41);
    host.recover(255);
    chk({9'h000, pkt_count}, 17'h00000);
    host.clr_rx_err();
    rchk(`EIS_ADDR_EIR, 8'h00);
    $display("test packets done");
    pulse(9'h001);
    pchk(`EIS_ADDR_PHY_IRQ_FLAGS, 16'h0010);
    pchk(`EIS_ADDR_PHY_IRQ_FLAGS, 16'h0000);
    host.pacc(1'b1, `EIS_ADDR_PHY_IRQ_ENABLE, 16'hffff, pd, v);
    pchk(`EIS_ADDR_PHY_IRQ_ENABLE, 16'h0012);
    pulse(9'h001);
    rchk(`EIS_ADDR_EIR, 8'h10);
    host.wr(EIS_OP_WRITE, `EIS_ADDR_EIR, 8'h00);
    rchk(`EIS_ADDR_EIR, 8'h10);
    pchk(`EIS_ADDR_PHY_IRQ_FLAGS, 16'h0014);
    rchk(`EIS_ADDR_EIR, 8'h00);
    $display("test phy done");
    complete_run();
  end

  initial begin
    #100000;
    n_fail++;
    $display("watchdog expired at %0t", $time);
    complete_run();
  end
endmodule
